// [core/ifd_pkg.sv]
// Shared constants, form codes and field layout for the instruction field decoder
package ifd_pkg;

  // ************************************************************
  // Register map (byte addresses)
  // ************************************************************
  localparam int          ADDR_W      = 12;
  localparam logic [11:0] CTRL_OFS    = 12'h000;
  localparam logic [11:0] STAT_OFS    = 12'h004;
  localparam logic [11:0] LAST_OFS    = 12'h008;
  localparam logic [3:0]  TABLE_PAGE  = 4'h1;
  localparam logic [31:0] CTRL_RST    = 32'h0000_0001;
  localparam int          CTRL_EN_BIT = 0;
  localparam int          TBL_LEGAL_BIT = 4;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  // ************************************************************
  // Field positions, little-endian bit index of the field LSB
  // ************************************************************
  localparam int OPC_POS  = 26;
  localparam int OPC_W    = 6;
  localparam int F6_POS   = 21;
  localparam int F11_POS  = 16;
  localparam int F16_POS  = 11;
  localparam int F21_POS  = 6;
  localparam int F26_POS  = 1;
  localparam int SEL_W    = 5;
  localparam int BF_POS   = 23;
  localparam int BFA_POS  = 18;
  localparam int CRF_W    = 3;
  localparam int FXM_POS  = 12;
  localparam int FXM_W    = 8;
  localparam int REGN_POS = 11;
  localparam int REGN_W   = 10;
  localparam int XO_POS   = 1;
  localparam int XO_W     = 10;
  localparam int XOE_W    = 9;
  localparam int OE_BIT   = 10;
  localparam int AA_BIT   = 1;
  localparam int LKRC_BIT = 0;
  localparam int BD_POS   = 2;
  localparam int BD_W     = 14;
  localparam int LI_POS   = 2;
  localparam int LI_W     = 24;
  localparam int IMM_W    = 16;

  // Instruction formats; table entries hold these codes in four bits
  typedef enum logic [3:0] {
    FORM_D, FORM_I, FORM_B, FORM_SC, FORM_X, FORM_X_NOB, FORM_X_NOAB,
    FORM_XL, FORM_XL_NOREG, FORM_XFX, FORM_XO, FORM_XO_NOB, FORM_M
  } ifd_form_t;

  localparam ifd_form_t FORM_RST = FORM_D;

endpackage : ifd_pkg

// [core/ifd_form_check.sv]
// Per-form reserved-field check and form-dependent flag presence
`timescale 1ns/1ns
module ifd_form_check (
  input  wire logic [31:0]       instr_word,
  input  wire ifd_pkg::ifd_form_t form,
  output logic                   rsvd_hit,
  output logic                   has_lk,
  output logic                   has_rc,
  output logic                   has_oe
);
  import ifd_pkg::*;

  logic [31:0] rsvd_mask;

  always_comb begin
    rsvd_mask = 32'h0000_0000;
    has_lk    = 1'b0;
    has_rc    = 1'b0;
    has_oe    = 1'b0;
    unique case (form)
      FORM_D:        rsvd_mask = 32'h0000_0000;
      FORM_I,
      FORM_B:        has_lk = 1'b1;
      FORM_SC:       rsvd_mask = 32'h03FF_FFFC;
      FORM_X:        has_rc = 1'b1;
      FORM_X_NOB: begin
        rsvd_mask = 32'h0000_F800;
        has_rc    = 1'b1;
      end
      FORM_X_NOAB: begin
        rsvd_mask = 32'h001F_F800;
        has_rc    = 1'b1;
      end
      FORM_XL:       has_lk = 1'b1;
      FORM_XL_NOREG: rsvd_mask = 32'h03FF_F800;
      FORM_XFX:      rsvd_mask = 32'h0000_0000;
      FORM_XO: begin
        has_rc = 1'b1;
        has_oe = 1'b1;
      end
      FORM_XO_NOB: begin
        rsvd_mask = 32'h0000_F800;
        has_rc    = 1'b1;
        has_oe    = 1'b1;
      end
      FORM_M:        has_rc = 1'b1;
      // Table codes above the last form carry no layout
      default:       rsvd_mask = 32'h0000_0000;
    endcase
  end

  // Reserved bits are reported, never trapped
  assign rsvd_hit = |(instr_word & rsvd_mask); // RL21

endmodule : ifd_form_check

// [core/ifd_decoder.sv]
// Instruction field decoder with AXI4-Lite opcode table and status
//
// What this block does
// (RL1) Relative branch target is sign-extended offset plus the branch address.
// (RL2) Absolute branch target is the sign-extended offset alone.
// (RL3) Conditional offset is bits 16-29, shifted left two, sign-extended.
// (RL4) Long offset is bits 6-29, shifted left two, sign-extended.
// (RL5) Bit 31 in branch forms requests a link write of the next address.
// (RL6) Bit 31 in record forms requests a condition register update.
// (RL7) Bit 21 in extended-arithmetic forms enables overflow and sticky error.
// (RL8) Primary opcode always comes from bits 0-5.
// (RL9) Extended opcode is bits 21-30, or 22-30 when bit 21 is overflow enable.
// (RL10) Register selectors: bits 11-15, bits 16-20 and bits 6-10.
// (RL11) Condition bit sources come from bits 11-15 and 16-20.
// (RL12) Condition bit destination comes from bits 6-10.
// (RL13) Branch tests the bit at 11-15; options come from bits 6-10.
// (RL14) Condition field target is bits 6-8, source field bits 11-13.
// (RL15) Bits 16-31 give a signed displacement or a sixteen-bit literal.
// (RL16) Bits 11-20 give a special or device control register number.
// (RL17) Bits 12-19 give the mask of condition fields to load.
// (RL18) Mask start is bits 21-25, mask stop bits 26-30.
// (RL19) String byte count comes from bits 16-20.
// (RL20) Trap conditions from bits 6-10; shift amount from bits 16-20.
// (RL21) Reserved fields are identified per form; producers keep them zero.
// (RL22) A wrong fixed opcode value flags the instruction illegal.
// (RL23) Nonzero reserved bits never make an instruction illegal.
// (RL24) All fields appear together one cycle later with a valid qualifier.
//
// The register offsets and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ns
module ifd_decoder (
  input  wire logic                       CLK,
  input  wire logic                       RST_N,
  // ************************************************************
  // AXI4-Lite register port
  // ************************************************************
  input  wire logic [ifd_pkg::ADDR_W-1:0] AWADDR,
  input  wire logic                       AWVALID,
  output logic                            AWREADY,
  input  wire logic [31:0]                WDATA,
  input  wire logic [3:0]                 WSTRB,
  input  wire logic                       WVALID,
  output logic                            WREADY,
  output logic [1:0]                      BRESP,
  output logic                            BVALID,
  input  wire logic                       BREADY,
  input  wire logic [ifd_pkg::ADDR_W-1:0] ARADDR,
  input  wire logic                       ARVALID,
  output logic                            ARREADY,
  output logic [31:0]                     RDATA,
  output logic [1:0]                      RRESP,
  output logic                            RVALID,
  input  wire logic                       RREADY,
  // ************************************************************
  // Fetch side
  // ************************************************************
  input  wire logic                       INSTR_VALID,
  input  wire logic [31:0]                INSTR_WORD,
  input  wire logic [31:0]                INSTR_ADDR,
  // ************************************************************
  // Pipeline side
  // ************************************************************
  output logic                            DEC_VALID,
  output ifd_pkg::ifd_form_t              DEC_FORM,
  output logic [5:0]                      PRIMARY_OPCODE,
  output logic [9:0]                      EXTENDED_OPCODE,
  output logic [4:0]                      GPR_SEL_ONE,
  output logic [4:0]                      GPR_SEL_TWO,
  output logic [4:0]                      GPR_SRC_DEST_SEL,
  output logic [4:0]                      COND_BIT_SRC_ONE,
  output logic [4:0]                      COND_BIT_SRC_TWO,
  output logic [4:0]                      COND_BIT_DEST,
  output logic [4:0]                      COND_TEST_SELECT,
  output logic [4:0]                      BRANCH_OPTION_CODE,
  output logic [2:0]                      COND_FIELD_DEST,
  output logic [2:0]                      COND_FIELD_SRC,
  output logic [7:0]                      COND_FIELD_MASK,
  output logic [9:0]                      SPECIAL_REG_NUM,
  output logic [9:0]                      DEVICE_CTL_REG_NUM,
  output logic [4:0]                      MASK_START_POS,
  output logic [4:0]                      MASK_STOP_POS,
  output logic [4:0]                      STRING_BYTE_COUNT,
  output logic [4:0]                      TRAP_COND_MASK,
  output logic [4:0]                      MOVE_DISTANCE,
  output logic [31:0]                     LOAD_STORE_DISP,
  output logic [15:0]                     SIXTEEN_BIT_LITERAL,
  output logic [31:0]                     BRANCH_TARGET,
  output logic [31:0]                     LINK_VALUE,
  output logic                            ABSOLUTE_MODE_FLAG,
  output logic                            LINK_UPDATE_FLAG,
  output logic                            RECORD_FLAG,
  output logic                            OVERFLOW_ENABLE_FLAG,
  output logic                            ILLEGAL_INSTR,
  output logic                            RESERVED_NONZERO
);
  import ifd_pkg::*;

  // ************************************************************
  // Helpers
  // ************************************************************
  function automatic logic [31:0] branch_dest(input logic        absolute,
                                              input logic [31:0] here,
                                              input logic [31:0] offset);
    branch_dest = absolute ? offset : here + offset; // RL1 RL2
  endfunction : branch_dest

  function automatic logic is_table(input logic [ADDR_W-1:0] addr);
    is_table = (addr[11:8] == TABLE_PAGE);
  endfunction : is_table

  // ************************************************************
  // Opcode table and control state
  // ************************************************************
  ifd_form_t   form_tbl [64];
  logic [63:0] legal_tbl;
  logic [31:0] ctrl_reg;
  logic [15:0] illegal_cnt_reg;
  logic [15:0] rsvd_cnt_reg;
  logic [31:0] last_illegal_reg;

  // ************************************************************
  // Write channel
  // ************************************************************
  logic              awready_reg;
  logic              wready_reg;
  logic              aw_pend_reg;
  logic              w_pend_reg;
  logic [ADDR_W-1:0] waddr_reg;
  logic [31:0]       wdata_reg;
  logic [3:0]        wstrb_reg;
  logic              bvalid_reg;
  logic [1:0]        bresp_reg;
  logic              aw_hs;
  logic              w_hs;
  logic              do_write;
  logic              wr_ok;

  assign aw_hs    = AWVALID & awready_reg;
  assign w_hs     = WVALID & wready_reg;
  // Hold the write until the previous response has been taken
  assign do_write = aw_pend_reg & w_pend_reg & ~bvalid_reg;
  assign wr_ok    = is_table(waddr_reg) || waddr_reg == CTRL_OFS || waddr_reg == STAT_OFS;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      aw_pend_reg <= 1'b0;
      awready_reg <= 1'b0;
      waddr_reg   <= '0;
    end else begin
      if (aw_hs) begin
        aw_pend_reg <= 1'b1;
        waddr_reg   <= AWADDR;
      end else if (do_write) begin
        aw_pend_reg <= 1'b0;
      end
      awready_reg <= aw_hs ? 1'b0 : (do_write | ~aw_pend_reg);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      w_pend_reg <= 1'b0;
      wready_reg <= 1'b0;
      wdata_reg  <= 32'h0000_0000;
      wstrb_reg  <= 4'h0;
    end else begin
      if (w_hs) begin
        w_pend_reg <= 1'b1;
        wdata_reg  <= WDATA;
        wstrb_reg  <= WSTRB;
      end else if (do_write) begin
        w_pend_reg <= 1'b0;
      end
      wready_reg <= w_hs ? 1'b0 : (do_write | ~w_pend_reg);
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      bvalid_reg <= 1'b0;
      bresp_reg  <= RESP_OKAY;
    end else if (do_write) begin
      bvalid_reg <= 1'b1;
      bresp_reg  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
    end else if (bvalid_reg && BREADY) begin
      bvalid_reg <= 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      ctrl_reg <= CTRL_RST;
    end else if (do_write && waddr_reg == CTRL_OFS) begin
      for (int b = 0; b < 4; b++) begin
        if (wstrb_reg[b]) begin
          ctrl_reg[b*8 +: 8] <= wdata_reg[b*8 +: 8];
        end
      end
    end
  end

  // Entry layout: form code in [3:0], legal flag in bit 4
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      legal_tbl <= {64{1'b1}};
      for (int i = 0; i < 64; i++) begin
        form_tbl[i] <= FORM_RST;
      end
    end else if (do_write && is_table(waddr_reg) && wstrb_reg[0]) begin
      form_tbl[waddr_reg[7:2]]  <= ifd_form_t'(wdata_reg[3:0]);
      legal_tbl[waddr_reg[7:2]] <= wdata_reg[TBL_LEGAL_BIT];
    end
  end

  // ************************************************************
  // Read channel
  // ************************************************************
  logic        arready_reg;
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic        ar_hs;
  logic [31:0] rd_word;
  logic        rd_ok;

  assign ar_hs = ARVALID & arready_reg;

  always_comb begin
    rd_word = 32'h0000_0000;
    rd_ok   = 1'b1;
    if (is_table(ARADDR)) begin
      rd_word[3:0]          = form_tbl[ARADDR[7:2]];
      rd_word[TBL_LEGAL_BIT] = legal_tbl[ARADDR[7:2]];
    end else if (ARADDR == CTRL_OFS) begin
      rd_word = ctrl_reg;
    end else if (ARADDR == STAT_OFS) begin
      rd_word = {rsvd_cnt_reg, illegal_cnt_reg};
    end else if (ARADDR == LAST_OFS) begin
      rd_word = last_illegal_reg;
    end else begin
      rd_ok = 1'b0;
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      arready_reg <= 1'b0;
      rvalid_reg  <= 1'b0;
      rdata_reg   <= 32'h0000_0000;
      rresp_reg   <= RESP_OKAY;
    end else begin
      arready_reg <= ~ar_hs & (~rvalid_reg | RREADY);
      if (ar_hs) begin
        rvalid_reg <= 1'b1;
        rdata_reg  <= rd_word;
        rresp_reg  <= rd_ok ? RESP_OKAY : RESP_SLVERR;
      end else if (rvalid_reg && RREADY) begin
        rvalid_reg <= 1'b0;
      end
    end
  end

  // ************************************************************
  // Form lookup and checks
  // ************************************************************
  logic [5:0]  opc;
  ifd_form_t   form;
  logic        rsvd_hit;
  logic        has_lk;
  logic        has_rc;
  logic        has_oe;
  logic        illegal;
  logic        take;
  logic [31:0] bd_ext;
  logic [31:0] li_ext;
  logic [31:0] target;

  assign opc  = INSTR_WORD[OPC_POS +: OPC_W]; // RL8
  assign form = form_tbl[opc];
  assign take = INSTR_VALID & ctrl_reg[CTRL_EN_BIT];

  ifd_form_check u_form_check (
    .instr_word (INSTR_WORD),
    .form       (form),
    .rsvd_hit   (rsvd_hit),
    .has_lk     (has_lk),
    .has_rc     (has_rc),
    .has_oe     (has_oe)
  );

  // Only the opcode table decides legality; reserved bits play no part
  assign illegal = ~legal_tbl[opc]; // RL22 RL23

  assign bd_ext = {{16{INSTR_WORD[BD_POS+BD_W-1]}}, INSTR_WORD[BD_POS +: BD_W], 2'b00}; // RL3
  assign li_ext = {{6{INSTR_WORD[LI_POS+LI_W-1]}}, INSTR_WORD[LI_POS +: LI_W], 2'b00}; // RL4
  assign target = branch_dest(INSTR_WORD[AA_BIT], INSTR_ADDR,
                              (form == FORM_I) ? li_ext : bd_ext); // RL1 RL2

  // ************************************************************
  // Status counters; a new event beats a clear in the same cycle
  // ************************************************************
  logic stat_clr;
  assign stat_clr = do_write && waddr_reg == STAT_OFS;

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      illegal_cnt_reg  <= 16'h0000;
      last_illegal_reg <= 32'h0000_0000;
    end else begin
      if (take && illegal) begin
        illegal_cnt_reg  <= stat_clr ? 16'h0001 : illegal_cnt_reg + 16'h0001;
        last_illegal_reg <= INSTR_WORD;
      end else if (stat_clr) begin
        illegal_cnt_reg <= 16'h0000;
      end
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      rsvd_cnt_reg <= 16'h0000;
    end else if (take && rsvd_hit) begin
      rsvd_cnt_reg <= stat_clr ? 16'h0001 : rsvd_cnt_reg + 16'h0001; // RL21
    end else if (stat_clr) begin
      rsvd_cnt_reg <= 16'h0000;
    end
  end

  // ************************************************************
  // Decode stage: every field is captured on the same edge
  // ************************************************************
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DEC_VALID <= 1'b0;
    end else begin
      DEC_VALID <= take; // RL24
    end
  end

  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      DEC_FORM             <= FORM_RST;
      PRIMARY_OPCODE       <= 6'h00;
      EXTENDED_OPCODE      <= 10'h000;
      GPR_SEL_ONE          <= 5'h00;
      GPR_SEL_TWO          <= 5'h00;
      GPR_SRC_DEST_SEL     <= 5'h00;
      COND_BIT_SRC_ONE     <= 5'h00;
      COND_BIT_SRC_TWO     <= 5'h00;
      COND_BIT_DEST        <= 5'h00;
      COND_TEST_SELECT     <= 5'h00;
      BRANCH_OPTION_CODE   <= 5'h00;
      COND_FIELD_DEST      <= 3'h0;
      COND_FIELD_SRC       <= 3'h0;
      COND_FIELD_MASK      <= 8'h00;
      SPECIAL_REG_NUM      <= 10'h000;
      DEVICE_CTL_REG_NUM   <= 10'h000;
      MASK_START_POS       <= 5'h00;
      MASK_STOP_POS        <= 5'h00;
      STRING_BYTE_COUNT    <= 5'h00;
      TRAP_COND_MASK       <= 5'h00;
      MOVE_DISTANCE        <= 5'h00;
      LOAD_STORE_DISP      <= 32'h0000_0000;
      SIXTEEN_BIT_LITERAL  <= 16'h0000;
      BRANCH_TARGET        <= 32'h0000_0000;
      LINK_VALUE           <= 32'h0000_0000;
      ABSOLUTE_MODE_FLAG   <= 1'b0;
      LINK_UPDATE_FLAG     <= 1'b0;
      RECORD_FLAG          <= 1'b0;
      OVERFLOW_ENABLE_FLAG <= 1'b0;
      ILLEGAL_INSTR        <= 1'b0;
      RESERVED_NONZERO     <= 1'b0;
    end else if (take) begin
      DEC_FORM            <= form;
      PRIMARY_OPCODE      <= opc; // RL8
      // Bit 21 belongs to the overflow enable in forms that carry it
      EXTENDED_OPCODE     <= has_oe ? {1'b0, INSTR_WORD[XO_POS +: XOE_W]}
                                    : INSTR_WORD[XO_POS +: XO_W]; // RL9
      GPR_SEL_ONE         <= INSTR_WORD[F11_POS +: SEL_W]; // RL10
      GPR_SEL_TWO         <= INSTR_WORD[F16_POS +: SEL_W]; // RL10
      GPR_SRC_DEST_SEL    <= INSTR_WORD[F6_POS +: SEL_W]; // RL10
      COND_BIT_SRC_ONE    <= INSTR_WORD[F11_POS +: SEL_W]; // RL11
      COND_BIT_SRC_TWO    <= INSTR_WORD[F16_POS +: SEL_W]; // RL11
      COND_BIT_DEST       <= INSTR_WORD[F6_POS +: SEL_W]; // RL12
      COND_TEST_SELECT    <= INSTR_WORD[F11_POS +: SEL_W]; // RL13
      BRANCH_OPTION_CODE  <= INSTR_WORD[F6_POS +: SEL_W]; // RL13
      COND_FIELD_DEST     <= INSTR_WORD[BF_POS +: CRF_W]; // RL14
      COND_FIELD_SRC      <= INSTR_WORD[BFA_POS +: CRF_W]; // RL14
      COND_FIELD_MASK     <= INSTR_WORD[FXM_POS +: FXM_W]; // RL17
      SPECIAL_REG_NUM     <= INSTR_WORD[REGN_POS +: REGN_W]; // RL16
      DEVICE_CTL_REG_NUM  <= INSTR_WORD[REGN_POS +: REGN_W]; // RL16
      MASK_START_POS      <= INSTR_WORD[F21_POS +: SEL_W]; // RL18
      MASK_STOP_POS       <= INSTR_WORD[F26_POS +: SEL_W]; // RL18
      STRING_BYTE_COUNT   <= INSTR_WORD[F16_POS +: SEL_W]; // RL19
      TRAP_COND_MASK      <= INSTR_WORD[F6_POS +: SEL_W]; // RL20
      MOVE_DISTANCE       <= INSTR_WORD[F16_POS +: SEL_W]; // RL20
      LOAD_STORE_DISP     <= {{16{INSTR_WORD[IMM_W-1]}}, INSTR_WORD[IMM_W-1:0]}; // RL15
      SIXTEEN_BIT_LITERAL <= INSTR_WORD[IMM_W-1:0]; // RL15
      BRANCH_TARGET       <= target; // RL1 RL2
      // Word-aligned fetch, so the next instruction sits four bytes on
      LINK_VALUE          <= INSTR_ADDR + 32'h0000_0004; // RL5
      ABSOLUTE_MODE_FLAG  <= INSTR_WORD[AA_BIT] & (form == FORM_I || form == FORM_B);
      LINK_UPDATE_FLAG    <= has_lk & INSTR_WORD[LKRC_BIT]; // RL5
      RECORD_FLAG         <= has_rc & INSTR_WORD[LKRC_BIT]; // RL6
      OVERFLOW_ENABLE_FLAG <= has_oe & INSTR_WORD[OE_BIT]; // RL7
      ILLEGAL_INSTR       <= illegal; // RL22
      RESERVED_NONZERO    <= rsvd_hit; // RL21 RL23
    end
  end

  // ************************************************************
  // Bus outputs
  // ************************************************************
  assign AWREADY = awready_reg;
  assign WREADY  = wready_reg;
  assign BVALID  = bvalid_reg;
  assign BRESP   = bresp_reg;
  assign ARREADY = arready_reg;
  assign RVALID  = rvalid_reg;
  assign RDATA   = rdata_reg;
  assign RRESP   = rresp_reg;

endmodule : ifd_decoder

// [test/ifd_fetch_model.sv]
// Fetch stage model that offers instruction words to the decoder
`timescale 1ns/1ns
module ifd_fetch_model (
  input  wire logic        clk,
  input  wire logic        go,
  input  wire logic [31:0] w,
  input  wire logic [31:0] a,
  output logic             iv,
  output logic [31:0]      iw,
  output logic [31:0]      ia
);
  initial begin
    iv = 1'b0;
    iw = 32'h0;
    ia = 32'h0;
  end
  // Idle lines toggle so a stale word can never pass for a fresh one
  always @(posedge clk) begin
    iv <= go;
    iw <= go ? w : ~iw;
    ia <= go ? a : ~ia;
  end
endmodule : ifd_fetch_model

// [test/ifd_asserts.sv]
// Checker for the decoded field outputs
`timescale 1ns/1ns
module ifd_asserts (
  input wire logic               CLK,
  input wire logic               RST_N,
  input wire logic               INSTR_VALID,
  input wire logic [31:0]        INSTR_WORD,
  input wire logic [31:0]        INSTR_ADDR,
  input wire logic               DEC_VALID,
  input wire ifd_pkg::ifd_form_t DEC_FORM,
  input wire logic [5:0]         PRIMARY_OPCODE,
  input wire logic [4:0]         GPR_SEL_ONE,
  input wire logic [4:0]         GPR_SEL_TWO,
  input wire logic [4:0]         GPR_SRC_DEST_SEL,
  input wire logic [4:0]         MASK_START_POS,
  input wire logic [4:0]         MASK_STOP_POS,
  input wire logic [31:0]        LOAD_STORE_DISP,
  input wire logic [31:0]        BRANCH_TARGET,
  input wire logic [31:0]        LINK_VALUE,
  input wire logic               ABSOLUTE_MODE_FLAG
);
  import ifd_pkg::*;
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RST_N);
  wire [31:0] off = {{16{INSTR_WORD[15]}}, INSTR_WORD[15:2], 2'b00} + (INSTR_WORD[1] ? 32'h0 : INSTR_ADDR);
  sequence s_br;
    DEC_VALID && DEC_FORM == FORM_B;
  endsequence
  idle_quiet_a: assert property (!INSTR_VALID |=> !DEC_VALID) else $error("decode without word");
  opc_field_a: assert property (DEC_VALID |-> PRIMARY_OPCODE == $past(INSTR_WORD[31:26]))
    else $error("primary opcode wrong");
  gpr_sel_a: assert property (DEC_VALID|->{GPR_SRC_DEST_SEL,GPR_SEL_ONE,GPR_SEL_TWO}==$past(INSTR_WORD[25:11]))
    else $error("register selectors wrong");
  disp_sext_a: assert property (DEC_VALID |-> LOAD_STORE_DISP == $past(32'($signed(INSTR_WORD[15:0]))))
    else $error("displacement wrong");
  link_next_a: assert property (DEC_VALID |-> LINK_VALUE == $past(INSTR_ADDR) + 32'h4)
    else $error("link value wrong");
  mask_pos_a: assert property (DEC_VALID |-> {MASK_START_POS, MASK_STOP_POS} == $past(INSTR_WORD[10:1]))
    else $error("mask bounds wrong");
  cond_target_a: assert property (s_br |-> BRANCH_TARGET == $past(off))
    else $error("branch target wrong");
  field_hold_a: assert property (!DEC_VALID |-> $stable(BRANCH_TARGET)) else $error("fields moved");
endmodule : ifd_asserts
bind ifd_decoder ifd_asserts chk_i (.CLK, .RST_N, .INSTR_VALID, .INSTR_WORD, .INSTR_ADDR, .DEC_VALID, .DEC_FORM,
  .PRIMARY_OPCODE, .GPR_SEL_ONE, .GPR_SEL_TWO, .GPR_SRC_DEST_SEL, .MASK_START_POS, .MASK_STOP_POS,
  .LOAD_STORE_DISP, .BRANCH_TARGET, .LINK_VALUE, .ABSOLUTE_MODE_FLAG);

// [test/ifd_decoder_test.sv]
// Self-checking bench for the instruction field decoder
`timescale 1ns/1ns
module ifd_decoder_test;
  import ifd_pkg::*;
  logic CLK = 0, RST_N = 0, AWVALID = 0, WVALID = 0, BREADY = 0, ARVALID = 0, RREADY = 0, go = 0;
  logic [11:0] AWADDR = 0, ARADDR = 0;
  logic [31:0] WDATA = 0, w = 0, a = 0, RDATA, INSTR_WORD, INSTR_ADDR, BRANCH_TARGET;
  logic [3:0] WSTRB = 0;
  logic [1:0] BRESP, RRESP;
  logic AWREADY, WREADY, BVALID, ARREADY, RVALID, INSTR_VALID, DEC_VALID;
  logic ILLEGAL_INSTR, RESERVED_NONZERO, ABSOLUTE_MODE_FLAG, LINK_UPDATE_FLAG, RECORD_FLAG, OVERFLOW_ENABLE_FLAG;
  logic [9:0] EXTENDED_OPCODE, SPECIAL_REG_NUM;
  logic [2:0] COND_FIELD_DEST, COND_FIELD_SRC;
  logic [4:0] COND_TEST_SELECT, BRANCH_OPTION_CODE;
  logic [5:0] fl;
  int bad_count = 0, n_tests = 0, i;
  int op[6] = '{18, 16, 31, 19, 21, 0};
  logic [31:0] tv[6] = '{32'h11, 32'h12, 32'h1A, 32'h16, 32'h1C, 32'h00};
  assign fl = {ILLEGAL_INSTR, RESERVED_NONZERO, ABSOLUTE_MODE_FLAG, LINK_UPDATE_FLAG, RECORD_FLAG, OVERFLOW_ENABLE_FLAG};
  always #50 CLK = ~CLK;
  ifd_fetch_model fm (.clk(CLK), .go(go), .w(w), .a(a), .iv(INSTR_VALID), .iw(INSTR_WORD), .ia(INSTR_ADDR));
  ifd_decoder uut (.CLK, .RST_N, .AWADDR, .AWVALID, .AWREADY, .WDATA, .WSTRB, .WVALID, .WREADY, .BRESP, .BVALID,
    .BREADY, .ARADDR, .ARVALID, .ARREADY, .RDATA, .RRESP, .RVALID, .RREADY, .INSTR_VALID, .INSTR_WORD, .INSTR_ADDR,
    .DEC_VALID, .DEC_FORM(), .PRIMARY_OPCODE(), .EXTENDED_OPCODE, .GPR_SEL_ONE(), .GPR_SEL_TWO(), .GPR_SRC_DEST_SEL(),
    .COND_BIT_SRC_ONE(), .COND_BIT_SRC_TWO(), .COND_BIT_DEST(), .COND_TEST_SELECT, .BRANCH_OPTION_CODE,
    .COND_FIELD_DEST, .COND_FIELD_SRC, .COND_FIELD_MASK(), .SPECIAL_REG_NUM, .DEVICE_CTL_REG_NUM(),
    .MASK_START_POS(), .MASK_STOP_POS(), .STRING_BYTE_COUNT(), .TRAP_COND_MASK(), .MOVE_DISTANCE(),
    .LOAD_STORE_DISP(), .SIXTEEN_BIT_LITERAL(), .BRANCH_TARGET, .LINK_VALUE(), .ABSOLUTE_MODE_FLAG,
    .LINK_UPDATE_FLAG, .RECORD_FLAG, .OVERFLOW_ENABLE_FLAG, .ILLEGAL_INSTR, .RESERVED_NONZERO);
  // ************************************************************
  // Access tasks
  // ************************************************************
  task automatic end_of_test(input bit tmo);
    if (tmo) bad_count++;
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic wr(input logic [11:0] ad, input logic [31:0] d, input logic [1:0] er);
    int k;
    @(posedge CLK);
    AWADDR <= ad;
    WDATA <= d;
    WSTRB <= 4'hF;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge CLK);
      if (AWREADY) AWVALID <= 1'b0;
      if (WREADY) WVALID <= 1'b0;
      if (BVALID === 1'b1) break;
    end
    BREADY <= 1'b0;
    if (k == 40) end_of_test(1);
    chk(BRESP, er);
  endtask : wr
  task automatic rd(input logic [11:0] ad, input logic [31:0] ed, input logic [1:0] er);
    int k;
    @(posedge CLK);
    ARADDR <= ad;
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    for (k = 0; k < 40; k++) begin
      @(posedge CLK);
      if (ARREADY) ARVALID <= 1'b0;
      if (RVALID === 1'b1) break;
    end
    RREADY <= 1'b0;
    if (k == 40) end_of_test(1);
    chk(RDATA, ed);
    chk(RRESP, er);
  endtask : rd
  task automatic dec(input logic [31:0] wd, input logic [31:0] ad);
    @(posedge CLK);
    w <= wd;
    a <= ad;
    go <= 1'b1;
    @(posedge CLK);
    go <= 1'b0;
    @(posedge CLK);
    #1;
  endtask : dec
  initial begin
    repeat (12) @(posedge CLK);
    RST_N <= 1'b1;
    rd(CTRL_OFS, CTRL_RST, RESP_OKAY);
    rd(12'h00C, 32'h0, RESP_SLVERR);
    for (i = 0; i < 6; i++) wr(12'h100 + 12'(4 * op[i]), tv[i], RESP_OKAY);
    dec({6'd18, 24'hFFFFFE, 2'b01}, 32'h1000);
    chk(DEC_VALID, 1);
    chk(BRANCH_TARGET, 32'h0FF8);
    chk(fl, 6'b000100);
    dec({6'd18, 24'hFFFFFE, 2'b10}, 32'h1000);
    chk(BRANCH_TARGET, 32'hFFFFFFF8);
    chk(fl, 6'b001000);
    dec({6'd16, 5'h0C, 5'h03, 14'h2000, 2'b00}, 32'h10000);
    chk(BRANCH_TARGET, 32'h8000);
    chk({COND_TEST_SELECT, BRANCH_OPTION_CODE}, {5'h03, 5'h0C});
    dec({6'd31, 15'h1D2B, 1'b1, 9'd491, 1'b1}, 32'h2000);
    chk(EXTENDED_OPCODE, 10'd491);
    chk(fl, 6'b000011);
    dec({6'd19, 5'd1, 10'h3FF, 10'd100, 1'b0}, 32'h2004);
    chk(EXTENDED_OPCODE, 10'd100);
    chk(fl, 6'b010000);
    chk({COND_FIELD_DEST, COND_FIELD_SRC, SPECIAL_REG_NUM}, {3'd0, 3'd7, 10'h3FF});
    dec({6'd21, 5'd2, 5'd3, 5'd4, 5'd5, 5'd30, 1'b0}, 32'h2008);
    chk(fl, 6'b000000);
    dec(32'h0000_1234, 32'h200C);
    chk(fl, 6'b100000);
    rd(STAT_OFS, 32'h0001_0001, RESP_OKAY);
    rd(LAST_OFS, 32'h0000_1234, RESP_OKAY);
    wr(CTRL_OFS, 32'h0, RESP_OKAY);
    dec({6'd18, 24'h1, 2'b00}, 32'h3000);
    chk(DEC_VALID, 0);
    end_of_test(0);
  end
endmodule : ifd_decoder_test
